// ### hdl/bsc_pkg.sv
package bsc_pkg;
    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int          BSC_REQ_W       = 8;
    localparam int          BSC_GNT_W       = 8;
    localparam int          BSC_IRQ_W       = 4;
    localparam int          BSC_SPARE_W     = 4;
    localparam int          BSC_FANOUT_W    = 9;
    localparam int          BSC_SYNC_STAGES = 2;

    // ----------------------------------------------------------------
    // request / grant pin positions in external arbiter mode
    // ----------------------------------------------------------------
    localparam int          BSC_OWN_POS     = 0;
    localparam int          BSC_SPARE_LO    = 2;
    localparam int          BSC_SPARE_HI    = 5;

    // ----------------------------------------------------------------
    // bus clock input range, in MHz
    // ----------------------------------------------------------------
    localparam int          BSC_BUS_CLK_MIN_MHZ = 10;
    localparam int          BSC_BUS_CLK_MAX_MHZ = 66;

    // ----------------------------------------------------------------
    // synchroniser vector layout
    // ----------------------------------------------------------------
    localparam int          BSC_SY_STRAP    = 0;
    localparam int          BSC_STRAP_W     = 6;
    localparam int          BSC_SY_REQ      = BSC_SY_STRAP + BSC_STRAP_W;
    localparam int          BSC_SY_IRQ      = BSC_SY_REQ + BSC_REQ_W;
    localparam int          BSC_SY_SCL      = BSC_SY_IRQ + BSC_IRQ_W;
    localparam int          BSC_SY_W        = BSC_SY_SCL + 1;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  BSC_GNT_RST     = 8'hff;
    localparam logic [3:0]  BSC_SPARE_RST   = 4'hf;
    localparam logic [3:0]  BSC_IRQ_OE_RST  = 4'h0;

    typedef struct packed {
        logic test_sel;
        logic sideband_sel;
        logic bridge_type;
        logic clock_mask;
        logic direction;
        logic arbiter_sel_n;
    } bsc_strap_t;

    localparam bsc_strap_t  BSC_STRAP_RST   = '0;

    typedef struct packed {
        bsc_strap_t                 strap;
        logic [BSC_GNT_W-1:0]       gnt_n;
        logic [BSC_SPARE_W-1:0]     spare_in;
        logic                       own_gnt_n;
        logic                       fan_en;
        logic [BSC_IRQ_W-1:0]       irq_oe;
        logic [BSC_IRQ_W-1:0]       irq_sync_n;
        logic                       scl_in;
        logic                       scl_oe;
        logic                       scl_out;
    } bsc_state_t;

endpackage : bsc_pkg

// ### hdl/bsc_sync.sv
`timescale 1ns/10ps
module bsc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } bsc_sync_st_t;

    bsc_sync_st_t sy_ff;
    bsc_sync_st_t nxt_sy;

    // no reset: straps must pass through while system reset is held
    // first stage is read only by the second stage
    always_comb begin
        nxt_sy.meta = i_async;
        nxt_sy.sync = sy_ff.meta;
    end

    always_ff @(posedge i_sys_clk) begin
        sy_ff <= nxt_sy;
    end

    assign o_sync = sy_ff.sync;
endmodule : bsc_sync

// ### hdl/bsc_strap_cfg.sv
`timescale 1ns/10ps
module bsc_strap_cfg
    import bsc_pkg::*;
#(
    parameter int BUS_CLK_MIN_MHZ = BSC_BUS_CLK_MIN_MHZ,
    parameter int BUS_CLK_MAX_MHZ = BSC_BUS_CLK_MAX_MHZ
) (
    // i_sys_clk is the loopback clock input
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_bus_rst_n,
    input  wire logic                    i_bus_clock_source_in,
    output logic [BSC_FANOUT_W-1:0]      o_bus_clock_fanout,
    input  wire logic                    i_test_select_strap,
    input  wire logic                    i_sideband_select_strap,
    input  wire logic                    i_bridge_type_strap,
    input  wire logic                    i_clock_mask_strap,
    input  wire logic                    i_direction_strap,
    input  wire logic                    i_arbiter_select_n,
    input  wire logic                    i_arbiter_select_n_driven,
    input  wire logic [BSC_REQ_W-1:0]    i_req_n,
    output logic      [BSC_GNT_W-1:0]    o_gnt_n,
    output logic      [BSC_GNT_W-1:0]    o_gnt_oe,
    input  wire logic [BSC_GNT_W-1:0]    i_arb_gnt_n,
    output logic      [BSC_REQ_W-1:0]    o_arb_req_n,
    input  wire logic                    i_own_req_n,
    output logic                         o_own_gnt_n,
    input  wire logic [BSC_SPARE_W-1:0]  i_spare_output,
    output logic      [BSC_SPARE_W-1:0]  o_spare_input,
    input  wire logic [BSC_IRQ_W-1:0]    i_irq_line_n,
    output logic      [BSC_IRQ_W-1:0]    o_irq_line_n,
    output logic      [BSC_IRQ_W-1:0]    o_irq_line_oe,
    input  wire logic [BSC_IRQ_W-1:0]    i_irq_req,
    output logic      [BSC_IRQ_W-1:0]    o_irq_sync_n,
    input  wire logic                    i_sideband_clock_pin,
    output logic                         o_sideband_clock_pin,
    output logic                         o_sideband_clock_oe,
    input  wire logic                    i_eeprom_scl,
    output logic                         o_smbus_scl,
    output logic                         o_test_mode,
    output logic                         o_normal_mode,
    output logic                         o_smbus_mode,
    output logic                         o_nontransparent,
    output logic                         o_reverse_mode,
    output logic                         o_ext_arbiter,
    output logic                         o_hotplug_en
);
    // ----------------------------------------------------------------
    // frequency range
    // ----------------------------------------------------------------
    // the range is a board limit; nothing here measures the clock
    localparam int BUS_CLK_SPAN_MHZ = BUS_CLK_MAX_MHZ - BUS_CLK_MIN_MHZ;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [BSC_SY_W-1:0] sy_in;
    logic [BSC_SY_W-1:0] sy_out;
    logic                drv_s;

    // drive flag synchronised on its own, so no gate sits ahead of a sync stage
    bsc_sync #(
        .W        (1)
    ) u_sync_drv (
        .i_sys_clk(i_sys_clk),
        .i_async  (i_arbiter_select_n_driven),
        .o_sync   (drv_s)
    );

    assign sy_in = {i_sideband_clock_pin,
                    i_irq_line_n,
                    i_req_n,
                    i_test_select_strap,
                    i_sideband_select_strap,
                    i_bridge_type_strap,
                    i_clock_mask_strap,
                    i_direction_strap,
                    i_arbiter_select_n};

    bsc_sync #(
        .W        (BSC_SY_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_async  (sy_in),
        .o_sync   (sy_out)
    );

    bsc_strap_t                 pin_strap;
    logic [BSC_REQ_W-1:0]       req_s;
    logic [BSC_IRQ_W-1:0]       irq_s;
    logic                       scl_s;

    always_comb begin
        pin_strap               = bsc_strap_t'(sy_out[BSC_SY_STRAP +: BSC_STRAP_W]);
        // an undriven select pin reads low, as the pull-down would make it
        pin_strap.arbiter_sel_n = sy_out[BSC_SY_STRAP] & drv_s;
    end
    assign req_s     = sy_out[BSC_SY_REQ +: BSC_REQ_W];
    assign irq_s     = sy_out[BSC_SY_IRQ +: BSC_IRQ_W];
    assign scl_s     = sy_out[BSC_SY_SCL];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    bsc_state_t st_ff;
    bsc_state_t nxt_st;
    bsc_strap_t sp;

    assign sp = st_ff.strap;

    always_comb begin
        nxt_st = st_ff;
        // straps follow the pins only while reset is held
        if (i_sys_rst) begin
            nxt_st.strap = pin_strap;
        end
        // arbitration pin mapping
        if (sp.arbiter_sel_n) begin
            nxt_st.own_gnt_n = req_s[BSC_OWN_POS];
            nxt_st.gnt_n = i_arb_gnt_n;
            nxt_st.gnt_n[BSC_OWN_POS] = i_own_req_n;
            nxt_st.gnt_n[BSC_SPARE_HI:BSC_SPARE_LO] = i_spare_output;
            nxt_st.spare_in = req_s[BSC_SPARE_HI:BSC_SPARE_LO];
        end else begin
            nxt_st.own_gnt_n = 1'b1;
            nxt_st.gnt_n = i_arb_gnt_n;
            nxt_st.spare_in = BSC_SPARE_RST;
        end
        // dynamic clock mask, low lets the clocks run
        nxt_st.fan_en = ~pin_strap.clock_mask;
        // interrupt direction
        if (sp.direction) begin
            nxt_st.irq_oe = i_irq_req;
            nxt_st.irq_sync_n = '1;
        end else begin
            nxt_st.irq_oe = '0;
            nxt_st.irq_sync_n = irq_s;
        end
        // sideband clock direction
        nxt_st.scl_oe = ~sp.sideband_sel;
        nxt_st.scl_out = i_eeprom_scl;
        nxt_st.scl_in = sp.sideband_sel ? scl_s : 1'b1;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            st_ff            <= '0;
            st_ff.strap      <= pin_strap;
            st_ff.gnt_n      <= BSC_GNT_RST;
            st_ff.spare_in   <= BSC_SPARE_RST;
            st_ff.own_gnt_n  <= 1'b1;
            st_ff.irq_oe     <= BSC_IRQ_OE_RST;
            st_ff.irq_sync_n <= '1;
            st_ff.scl_in     <= 1'b1;
            st_ff.scl_out    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // mode outputs
    // ----------------------------------------------------------------
    assign o_test_mode      = sp.test_sel;
    assign o_normal_mode    = ~sp.test_sel;
    assign o_smbus_mode     = sp.sideband_sel;
    assign o_nontransparent = sp.bridge_type;
    assign o_reverse_mode   = sp.direction;
    assign o_ext_arbiter    = sp.arbiter_sel_n;
    assign o_hotplug_en     = sp.clock_mask;

    // ----------------------------------------------------------------
    // arbitration pins
    // ----------------------------------------------------------------
    // repurposed request bits never reach the internal arbiter
    always_comb begin
        o_arb_req_n = req_s;
        if (sp.arbiter_sel_n) begin
            o_arb_req_n = '1;
        end
    end

    assign o_own_gnt_n   = st_ff.own_gnt_n;
    assign o_spare_input = st_ff.spare_in;
    assign o_gnt_n       = st_ff.gnt_n;
    // bus reset floats pins with no clock involved
    assign o_gnt_oe      = {BSC_GNT_W{i_bus_rst_n}};

    // ----------------------------------------------------------------
    // interrupt pins
    // ----------------------------------------------------------------
    assign o_irq_line_n  = '0;
    assign o_irq_line_oe = st_ff.irq_oe & {BSC_IRQ_W{i_bus_rst_n}};
    assign o_irq_sync_n  = st_ff.irq_sync_n;

    // ----------------------------------------------------------------
    // sideband clock pin
    // ----------------------------------------------------------------
    assign o_sideband_clock_pin = st_ff.scl_out;
    assign o_sideband_clock_oe  = st_ff.scl_oe;
    assign o_smbus_scl          = st_ff.scl_in;

    // ----------------------------------------------------------------
    // clock fan-out
    // ----------------------------------------------------------------
    // gating with a flop trades a possible runt pulse for simplicity
    assign o_bus_clock_fanout =
        {BSC_FANOUT_W{i_bus_clock_source_in & st_ff.fan_en & i_bus_rst_n}};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic past_rst;
    always_ff @(posedge i_sys_clk) begin
        past_rst <= i_sys_rst;
    end

    sequence s_rst_release;
        past_rst && !i_sys_rst;
    endsequence

    sequence s_straps_steady;
        $stable(st_ff.strap) [*4];
    endsequence

    a_strap_hold: assert property (
        s_rst_release |=> s_straps_steady)
        else $error("strap latch moved after reset");

    a_test_mode: assert property (
        o_test_mode == !o_normal_mode && o_test_mode == sp.test_sel)
        else $error("test and normal mode disagree");

    a_side_dir: assert property (
        !past_rst |-> o_sideband_clock_oe == !o_smbus_mode)
        else $error("sideband clock direction wrong");

    a_own_grant: assert property (
        o_ext_arbiter && $stable(o_ext_arbiter) |=>
        o_own_gnt_n == $past(req_s[BSC_OWN_POS]))
        else $error("own grant not taken from request 0");

    a_own_req: assert property (
        o_ext_arbiter |=> o_gnt_n[BSC_OWN_POS] == $past(i_own_req_n))
        else $error("own request not on grant 0");

    a_spare_out: assert property (
        o_ext_arbiter |=>
        o_gnt_n[BSC_SPARE_HI:BSC_SPARE_LO] == $past(i_spare_output))
        else $error("spare outputs not on grant 5..2");

    a_int_arb: assert property (
        !o_ext_arbiter |=> o_gnt_n == $past(i_arb_gnt_n) && o_own_gnt_n)
        else $error("internal arbiter grants not passed");

    a_ext_req_mask: assert property (
        o_ext_arbiter |-> o_arb_req_n == '1)
        else $error("requests reach arbiter in external mode");

    a_irq_fwd: assert property (
        !o_reverse_mode |-> ##1 (o_irq_line_oe == '0)
        ##1 (o_irq_sync_n == $past(irq_s)))
        else $error("forward irq not synchronised");

    a_irq_rev: assert property (
        o_reverse_mode |=>
        o_irq_line_oe == ($past(i_irq_req) & {BSC_IRQ_W{i_bus_rst_n}}))
        else $error("reverse irq drive wrong");

    a_bus_float: assert property (
        !i_bus_rst_n |-> o_gnt_oe == '0 && o_irq_line_oe == '0
        && o_bus_clock_fanout == '0)
        else $error("bus pins driven in bus reset");

    a_hotplug: assert property (
        !past_rst |-> o_hotplug_en == sp.clock_mask && $stable(o_hotplug_en))
        else $error("hot-plug enable changed");

    // ----------------------------------------------------------------
    // mode hold, pin mapping and fan-out checks
    // ----------------------------------------------------------------
    a_mode_hold: assert property (
        !past_rst |->
        $stable({o_smbus_mode, o_nontransparent, o_reverse_mode, o_ext_arbiter}))
        else $error("latched mode moved after reset");

    a_arb_pull: assert property (
        !drv_s |-> !pin_strap.arbiter_sel_n)
        else $error("undriven arbiter select not read low");

    a_fan_mask: assert property (
        pin_strap.clock_mask |=> o_bus_clock_fanout == '0)
        else $error("clock outputs run while masked");

    a_fan_src: assert property (
        !pin_strap.clock_mask |=>
        o_bus_clock_fanout == {BSC_FANOUT_W{i_bus_clock_source_in && i_bus_rst_n}})
        else $error("clock outputs do not follow source");

    a_spare_in: assert property (
        o_ext_arbiter |=>
        o_spare_input == $past(req_s[BSC_SPARE_HI:BSC_SPARE_LO]))
        else $error("spare inputs not taken from request 5..2");

    a_int_spare: assert property (
        !o_ext_arbiter |=> o_spare_input == BSC_SPARE_RST)
        else $error("spare inputs active with internal arbiter");

    a_int_req: assert property (
        !o_ext_arbiter |-> o_arb_req_n == req_s)
        else $error("requests do not reach internal arbiter");

    a_scl_drive: assert property (
        !o_smbus_mode |=> o_sideband_clock_pin == $past(i_eeprom_scl))
        else $error("sideband clock not driven from eeprom side");

    a_scl_in: assert property (
        o_smbus_mode |=> o_smbus_scl == $past(scl_s))
        else $error("smbus clock not taken from pin");

    a_scl_idle: assert property (
        !o_smbus_mode |=> o_smbus_scl == 1'b1)
        else $error("smbus clock not idle in eeprom mode");

endmodule : bsc_strap_cfg

// ### testbench/bsc_board.sv
`timescale 1ns/10ps
module bsc_board
    import bsc_pkg::*;
(
    input  wire logic [BSC_IRQ_W-1:0] i_irq_oe,
    input  wire logic [BSC_IRQ_W-1:0] i_irq_out_n,
    input  wire logic [BSC_IRQ_W-1:0] i_dev_irq_n,
    input  wire logic                 i_scl_oe,
    input  wire logic                 i_scl_out,
    input  wire logic                 i_dev_scl_oe,
    input  wire logic                 i_dev_scl,
    output logic      [BSC_IRQ_W-1:0] o_irq_pin_n,
    output logic                      o_scl_pin
);
    // ----------------------------------------------------------------
    // pull-up nets
    // ----------------------------------------------------------------
    // open-drain parties only pull low; a line nobody pulls reads high
    always_comb begin
        o_irq_pin_n = i_dev_irq_n & ~(i_irq_oe & ~i_irq_out_n);
        if (i_scl_oe && i_dev_scl_oe) begin
            o_scl_pin = i_scl_out & i_dev_scl;
        end else if (i_scl_oe) begin
            o_scl_pin = i_scl_out;
        end else if (i_dev_scl_oe) begin
            o_scl_pin = i_dev_scl;
        end else begin
            o_scl_pin = 1'b1;
        end
    end
endmodule : bsc_board

// ### testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import bsc_pkg::*;
;
    logic       clk, rst, brst_n, src, drv_n, own_req, e_scl, d_scl;
    logic [6:0] p;
    logic [5:0] sp;
    logic [7:0] req, agnt, gnt, gnt_oe, areq;
    logic [3:0] spo, spi, dirq, ipin, iout, ioe, ireq, isync;
    logic [8:0] fan;
    logic       own_gnt, sbo, sboe, scl_pin, smb, tm, nm, sm, nt, rv, ea, hp;
    logic [15:0] r;
    int         err_count, samples_checked;

    bsc_strap_cfg u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_bus_rst_n(brst_n),
        .i_bus_clock_source_in(src), .o_bus_clock_fanout(fan),
        .i_test_select_strap(sp[5]), .i_sideband_select_strap(sp[4]),
        .i_bridge_type_strap(sp[3]), .i_clock_mask_strap(sp[2]),
        .i_direction_strap(sp[1]), .i_arbiter_select_n(sp[0]),
        .i_arbiter_select_n_driven(drv_n), .i_req_n(req), .o_gnt_n(gnt),
        .o_gnt_oe(gnt_oe), .i_arb_gnt_n(agnt), .o_arb_req_n(areq),
        .i_own_req_n(own_req), .o_own_gnt_n(own_gnt), .i_spare_output(spo),
        .o_spare_input(spi), .i_irq_line_n(ipin), .o_irq_line_n(iout),
        .o_irq_line_oe(ioe), .i_irq_req(ireq), .o_irq_sync_n(isync),
        .i_sideband_clock_pin(scl_pin), .o_sideband_clock_pin(sbo),
        .o_sideband_clock_oe(sboe), .i_eeprom_scl(e_scl), .o_smbus_scl(smb),
        .o_test_mode(tm), .o_normal_mode(nm), .o_smbus_mode(sm),
        .o_nontransparent(nt), .o_reverse_mode(rv), .o_ext_arbiter(ea),
        .o_hotplug_en(hp));

    bsc_board u_board (.i_irq_oe(ioe), .i_irq_out_n(iout), .i_dev_irq_n(dirq),
        .i_scl_oe(sboe), .i_scl_out(sbo), .i_dev_scl_oe(p[5]), .i_dev_scl(d_scl),
        .o_irq_pin_n(ipin), .o_scl_pin(scl_pin));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // latched modes must match the pattern present during reset
    task automatic chk_modes();
        chk("test", tm, p[6]);
        chk("normal", nm, !p[6]);
        chk("smbus", sm, p[5]);
        chk("nontransp", nt, p[4]);
        chk("hotplug", hp, p[3]);
        chk("reverse", rv, p[2]);
        chk("ext_arb", ea, p[1] & p[0]);
    endtask : chk_modes

    // ----------------------------------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial begin
        rst = 1'b1; brst_n = 1'b1; src = 1'b1; drv_n = 1'b0; own_req = 1'b1;
        e_scl = 1'b1; d_scl = 1'b1; p = '0; sp = '0; req = 8'hff; agnt = 8'hff;
        spo = 4'hf; dirq = 4'hf; ireq = 4'h0; r = 16'h0019;
        err_count = 0; samples_checked = 0;
        for (int it = 0; it < 10; it++) begin
            r = lfsr(r);
            // corners first: all straps low, all high, then random
            p = (it == 0) ? 7'h00 : (it == 1) ? 7'h7f : r[6:0];
            @(negedge clk);
            sp = p[6:1];
            drv_n = p[0];
            rst = 1'b1;
            cyc(3);
            rst = 1'b0;
            cyc(1);
            chk_modes();
            sp = ~p[6:1] & 6'h3b;
            drv_n = ~p[0];
            cyc(4);
            chk_modes();
            chk("fan_on", fan, 9'h1ff);
            sp[2] = 1'b1;
            cyc(4);
            chk("fan_off", fan, 9'h000);
            sp[2] = 1'b0;
            cyc(4);
            chk("gnt_oe", gnt_oe, 8'hff);
            for (int k = 0; k < 4; k++) begin
                r = lfsr(r);
                req = r[7:0]; spo = r[11:8]; own_req = r[12]; agnt = r[15:8];
                ireq = r[3:0] | 4'h1; dirq = r[7:4]; e_scl = r[13]; d_scl = r[14];
                src = r[9];
                cyc(1);
                chk("fan_src", fan, src ? 9'h1ff : 9'h000);
                if (p[1] && p[0]) begin
                    chk("gnt_spare", gnt[5:2], spo);
                    chk("gnt_own", gnt[0], own_req);
                end else begin
                    chk("gnt", gnt, agnt);
                end
                chk("irq_oe", ioe, p[2] ? ireq : 4'h0);
                chk("irq_out", iout, 4'h0);
                chk("scl_oe", sboe, !p[5]);
                if (!p[5]) chk("scl_out", sbo, e_scl);
                cyc(2);
                chk("own_gnt", own_gnt, (p[1] && p[0]) ? req[0] : 1'b1);
                chk("spare_in", spi, (p[1] && p[0]) ? req[5:2] : 4'hf);
                chk("arb_req", areq, (p[1] && p[0]) ? 8'hff : req);
                chk("irq_sync", isync, p[2] ? 4'hf : dirq);
                chk("smb_scl", smb, p[5] ? d_scl : 1'b1);
                brst_n = 1'b0;
                #1;
                chk("rst_gnt_oe", gnt_oe, 8'h00);
                chk("rst_irq_oe", ioe, 4'h0);
                chk("rst_fan", fan, 9'h000);
                cyc(1);
                brst_n = 1'b1;
                cyc(1);
            end
            ireq = 4'h0;
            src = 1'b1;
            cyc(1);
            chk("irq_clr", ioe, 4'h0);
        end
        close_out();
    end
endmodule : tb_top
